//--- src/sesp_defs.svh
`ifndef SESP_DEFS_SVH
`define SESP_DEFS_SVH

// system clock and programming time
`define SESP_CLK_MHZ        100
`define SESP_PROG_TIME_MS   5
`define SESP_PROG_CYCLES    (`SESP_PROG_TIME_MS * 1000 * `SESP_CLK_MHZ)
`define SESP_TMR_W          24

// device address word
`define SESP_DEV_TYPE       4'ha
`define SESP_DEV_TYPE_MSB   7
`define SESP_DEV_TYPE_LSB   4
`define SESP_DEV_CS_MSB     3
`define SESP_DEV_CS_LSB     1
`define SESP_DEV_RW_BIT     0

// byte framing
`define SESP_LAST_DATA_BIT  4'h7
`define SESP_ACK_BIT        4'h8

// memory and page geometry
`define SESP_ADDR_W         16
`define SESP_PAGE_W         7
`define SESP_PAGE_BYTES     128
`define SESP_MEM_BYTES      65536
`define SESP_IDX_W          8

// synchronised pin vector layout and reset value
`define SESP_PIN_W          6
`define SESP_PIN_SCL        0
`define SESP_PIN_SDA        1
`define SESP_PIN_WP         2
`define SESP_PIN_CS_LSB     3
`define SESP_PIN_CS_MSB     5
`define SESP_PIN_RST        6'h03

`endif

//--- src/sesp_pkg.sv
package sesp_pkg;

  typedef enum logic [2:0] {
    SESP_ST_IDLE = 3'b000,
    SESP_ST_DEV  = 3'b001,
    SESP_ST_ADH  = 3'b010,
    SESP_ST_ADL  = 3'b011,
    SESP_ST_DAT  = 3'b100,
    SESP_ST_RD   = 3'b101,
    SESP_ST_IGN  = 3'b110
  } sesp_state_t;

endpackage

//--- src/sesp_sync.sv
`timescale 1ns/1ns

module sesp_sync #(
  parameter int unsigned             WIDTH   = 1,
  parameter logic [WIDTH-1:0]        RST_VAL = '0
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [WIDTH-1:0]      din,
  output logic      [WIDTH-1:0]      dout
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      s2_q   <= RST_VAL;
      s3_q   <= RST_VAL;
    end else begin
      meta_q <= din;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
    end
  end

  // a bit moves only once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      dout <= RST_VAL;
    end else begin
      for (int i = 0; i < int'(WIDTH); i++) begin
        if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s3_q[i];
        end
      end
    end
  end

endmodule // sesp_sync

//--- src/sesp_slave_port.sv
`timescale 1ns/1ns
`include "sesp_defs.svh"

// How it works
// RULE1 - sda changes with scl high are only ever taken as start or stop
// RULE2 - sda falling while scl high is a start; it opens every command
// RULE3 - sda rising while scl high is a stop; after a read it means standby
// RULE4 - bytes are eight bits; device pulls sda low on ninth clock to ack
// RULE5 - standby after reset and after a stop once programming is finished
// RULE6 - start, nine clocks, start, stop leaves the port ready again
// RULE7 - programming lasts at most five milliseconds from the closing stop
// RULE8 - address word follows start; upper four bits are a fixed pattern
// RULE9 - next three address bits must equal the chip select straps
// RULE10 - last address bit: one means read, zero means write
// RULE11 - matching address is acked; a mismatch returns to standby, ignoring rest
// RULE12 - write protect high blocks every write to the array
// RULE13 - write sends two address bytes then data, each one acked
// RULE14 - a byte write ends with stop, which starts programming
// RULE15 - while programming the port ignores the bus and gives no ack
// RULE16 - page write takes up to 128 data bytes, every one acked
// RULE17 - page is programmed only after the closing stop
// RULE18 - unconnected chip select straps count as low
// RULE19 - 512 pages of 128 bytes, 16-bit address, high byte first
// RULE20 - only the low seven address bits advance, wrapping inside the page
// RULE21 - address polling is nacked while programming, acked once done
// RULE22 - fixed upper address bits are 1010, most significant first
module sesp_slave_port #(
  parameter int unsigned PROG_CYCLES = `SESP_PROG_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        scl,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        wp,
  input  wire logic [2:0]  chip_select_straps,
  output logic             standby,
  output logic             busy,
  output logic             wr_dropped,
  output logic [15:0]      word_addr,
  input  wire logic [15:0] dbg_addr,
  output logic [7:0]       dbg_data
);

  logic [`SESP_PIN_W-1:0]      pins_s;
  logic                        scl_s;
  logic                        sda_s;
  logic                        wp_s;
  logic [2:0]                  cs_s;
  logic                        scl_p_q;
  logic                        sda_p_q;
  logic                        scl_rise;
  logic                        scl_fall;
  logic                        start_ev;
  logic                        stop_ev;
  logic                        byte_done;
  logic [7:0]                  link_shreg_q;
  logic [7:0]                  rx_byte;
  sesp_pkg::sesp_state_t       state_q;
  sesp_pkg::sesp_state_t       nxt_q;
  logic [3:0]                  bit_cnt_q;
  logic                        ack_q;
  logic                        oe_q;
  logic [`SESP_ADDR_W-1:0]     addr_q;
  logic                        wr_pend_q;
  logic [`SESP_PAGE_BYTES-1:0] vld_q;
  logic [7:0]                  page_buf [`SESP_PAGE_BYTES];
  logic [7:0]                  mem [`SESP_MEM_BYTES];
  logic                        busy_q;
  logic [`SESP_IDX_W-1:0]      idx_q;
  logic [`SESP_TMR_W-1:0]      tmr_q;
  logic                        prog_stop;
  logic                        prog_go;
  logic                        prog_end;
  logic                        wr_drop_q;
  logic [7:0]                  dbg_q;
  logic                        data_done;
  logic                        standby_q;

  // address word check: fixed device type and strap match
  function automatic logic dev_match(input logic [7:0] w, input logic [2:0] cs);
    logic type_ok;
    logic cs_ok;
    type_ok = (w[`SESP_DEV_TYPE_MSB:`SESP_DEV_TYPE_LSB] == `SESP_DEV_TYPE); // RULE8 RULE22
    cs_ok   = (w[`SESP_DEV_CS_MSB:`SESP_DEV_CS_LSB] == cs); // RULE9
    return type_ok & cs_ok;
  endfunction

  // receive states that count bits and ack bytes
  function automatic logic takes_bytes(input sesp_pkg::sesp_state_t s);
    return (s == sesp_pkg::SESP_ST_DEV) || (s == sesp_pkg::SESP_ST_ADH) ||
           (s == sesp_pkg::SESP_ST_ADL) || (s == sesp_pkg::SESP_ST_DAT);
  endfunction

  // slot of an address inside its page
  function automatic logic [`SESP_PAGE_W-1:0] slot_of(input logic [`SESP_ADDR_W-1:0] a);
    return a[`SESP_PAGE_W-1:0];
  endfunction

  // copy pointer still inside the page; stops one past the last slot
  function automatic logic copy_live(input logic [`SESP_IDX_W-1:0] i);
    return i != 8'(`SESP_PAGE_BYTES);
  endfunction

  // link domain: scl clocks the data in on its rising edge
  always_ff @(posedge scl) begin
    link_shreg_q <= {link_shreg_q[6:0], sda_i}; // RULE4
  end

  // the shift word is read only after the synchronised scl has risen;
  // it then stands still until the next rising scl, a whole clock low away
  // limitation: scl high must outlast the pin filter, about five system clocks
  assign rx_byte = link_shreg_q;

  sesp_sync #(
    .WIDTH   (`SESP_PIN_W),
    .RST_VAL (`SESP_PIN_RST)
  ) u_sync (
    .clk  (sys_clk),
    .rst  (sys_rst),
    .din  ({chip_select_straps, wp, sda_i, scl}),
    .dout (pins_s)
  );

  assign scl_s = pins_s[`SESP_PIN_SCL];
  assign sda_s = pins_s[`SESP_PIN_SDA];
  assign wp_s  = pins_s[`SESP_PIN_WP];
  // floating straps rely on pad pull-downs; the core sees them as low
  assign cs_s  = pins_s[`SESP_PIN_CS_MSB:`SESP_PIN_CS_LSB]; // RULE18

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  // sda moving while scl stays high is a bus condition, never data
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s; // RULE1 RULE2
  assign stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s; // RULE1 RULE3

  assign byte_done = scl_rise && (bit_cnt_q == `SESP_LAST_DATA_BIT) && takes_bytes(state_q);
  // a data byte landed; it feeds the page buffer and the pending write
  assign data_done = byte_done && (state_q == sesp_pkg::SESP_ST_DAT);

  // protocol sequencer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q   <= sesp_pkg::SESP_ST_IDLE; // RULE5
      nxt_q     <= sesp_pkg::SESP_ST_IDLE;
      bit_cnt_q <= 4'h0;
      ack_q     <= 1'b0;
    end else if (start_ev) begin
      // any start, also a repeated one, restarts the word count
      state_q   <= sesp_pkg::SESP_ST_DEV; // RULE2 RULE6
      bit_cnt_q <= 4'h0;
      ack_q     <= 1'b0;
    end else if (stop_ev) begin
      state_q   <= sesp_pkg::SESP_ST_IDLE; // RULE3 RULE5
      bit_cnt_q <= 4'h0;
      ack_q     <= 1'b0;
    end else if (scl_rise) begin
      case (state_q)
        sesp_pkg::SESP_ST_DEV,
        sesp_pkg::SESP_ST_ADH,
        sesp_pkg::SESP_ST_ADL,
        sesp_pkg::SESP_ST_DAT: begin
          if (bit_cnt_q == `SESP_ACK_BIT) begin
            bit_cnt_q <= 4'h0;
            ack_q     <= 1'b0;
            state_q   <= ack_q ? nxt_q : sesp_pkg::SESP_ST_IGN; // RULE11
          end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          if (byte_done) begin
            case (state_q)
              sesp_pkg::SESP_ST_DEV: begin
                // polling during programming sees no ack
                ack_q <= dev_match(rx_byte, cs_s) & ~busy_q; // RULE11 RULE15 RULE21
                nxt_q <= rx_byte[`SESP_DEV_RW_BIT] ? sesp_pkg::SESP_ST_RD
                                                   : sesp_pkg::SESP_ST_ADH; // RULE10
              end
              sesp_pkg::SESP_ST_ADH: begin
                ack_q <= 1'b1; // RULE13
                nxt_q <= sesp_pkg::SESP_ST_ADL;
              end
              sesp_pkg::SESP_ST_ADL: begin
                ack_q <= 1'b1; // RULE13
                nxt_q <= sesp_pkg::SESP_ST_DAT;
              end
              sesp_pkg::SESP_ST_DAT: begin
                ack_q <= 1'b1; // RULE13 RULE16
                nxt_q <= sesp_pkg::SESP_ST_DAT;
              end
              default: begin
                ack_q <= 1'b0;
                nxt_q <= sesp_pkg::SESP_ST_IGN;
              end
            endcase
          end
        end
        default: begin
          bit_cnt_q <= 4'h0;
        end
      endcase
    end
  end

  // ack driver: pull low from the eighth falling edge to the ninth
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      oe_q <= 1'b0;
    end else if (start_ev || stop_ev) begin
      oe_q <= 1'b0;
    end else if (scl_fall) begin
      oe_q <= (bit_cnt_q == `SESP_ACK_BIT) && ack_q; // RULE4
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = oe_q;

  // word address, high byte first
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      addr_q <= '0;
    end else if (byte_done) begin
      case (state_q)
        sesp_pkg::SESP_ST_ADH: begin
          addr_q[15:8] <= rx_byte; // RULE19
        end
        sesp_pkg::SESP_ST_ADL: begin
          addr_q[7:0] <= rx_byte; // RULE19
        end
        sesp_pkg::SESP_ST_DAT: begin
          // page bits stay put so a long burst wraps and overwrites
          addr_q[`SESP_PAGE_W-1:0] <= slot_of(addr_q) + 7'h01; // RULE20
        end
        default: begin
          addr_q <= addr_q;
        end
      endcase
    end
  end

  assign word_addr = addr_q;

  // page buffer holds data until the stop
  always_ff @(posedge sys_clk) begin
    if (data_done) begin
      page_buf[slot_of(addr_q)] <= rx_byte; // RULE16 RULE20
    end
  end

  assign prog_stop = stop_ev && wr_pend_q && !busy_q;
  assign prog_go   = prog_stop && !wp_s; // RULE12 RULE14 RULE17
  assign prog_end  = busy_q && (tmr_q == PROG_CYCLES[`SESP_TMR_W-1:0] - 24'h1);

  // buffered bytes and the pending write
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      vld_q     <= '0;
      wr_pend_q <= 1'b0;
    end else if (data_done) begin
      vld_q[slot_of(addr_q)] <= 1'h1;
      wr_pend_q                       <= 1'b1;
    end else if (prog_end || (prog_stop && wp_s) || (start_ev && !busy_q)) begin
      // a new start without a stop abandons the unfinished write
      vld_q     <= '0;
      wr_pend_q <= 1'b0;
    end else if (prog_go) begin
      wr_pend_q <= 1'b0;
    end
  end

  // protected write: buffer is dropped and reported
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_drop_q <= 1'b0;
    end else begin
      wr_drop_q <= prog_stop && wp_s; // RULE12
    end
  end

  assign wr_dropped = wr_drop_q;

  // self-timed programming cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      tmr_q  <= '0;
      idx_q  <= '0;
    end else if (prog_go) begin
      busy_q <= 1'b1; // RULE14 RULE15
      tmr_q  <= '0;
      idx_q  <= '0;
    end else if (busy_q) begin
      tmr_q <= tmr_q + 24'h1;
      if (copy_live(idx_q)) begin
        idx_q <= idx_q + 8'h01;
      end
      if (prog_end) begin
        busy_q <= 1'b0; // RULE7
      end
    end
  end

  assign busy = busy_q;

  // array update; the copy ends long before the timer does
  always_ff @(posedge sys_clk) begin
    if (busy_q && copy_live(idx_q) && vld_q[idx_q[`SESP_PAGE_W-1:0]]) begin
      mem[{addr_q[15:`SESP_PAGE_W], idx_q[`SESP_PAGE_W-1:0]}] <=
        page_buf[idx_q[`SESP_PAGE_W-1:0]]; // RULE17 RULE19
    end
  end

  // side port to look into the array
  always_ff @(posedge sys_clk) begin
    dbg_q <= mem[dbg_addr];
  end

  assign dbg_data = dbg_q;

  // held in a flop so the pin never glitches on the state decode
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      standby_q <= 1'h1; // RULE5
    end else begin
      standby_q <= ((state_q == sesp_pkg::SESP_ST_IDLE) ||
                    (state_q == sesp_pkg::SESP_ST_IGN)) && !busy_q; // RULE5 RULE11
    end
  end

  assign standby = standby_q;

endmodule // sesp_slave_port

//--- tb/sesp_slave_port_sva.sv
`timescale 1ns/1ns
module sesp_slave_port_sva #(
  parameter int unsigned PROG_CYCLES = 300
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic wp,
  input wire logic standby,
  input wire logic busy,
  input wire logic wr_dropped
);
  int unsigned cnt_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !busy) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  sequence idle_s;
    !busy [*4];
  endsequence
  sequence ack_hold_s;
    sda_oe [*8];
  endsequence
  AST_HOLD:
    assert property ($rose(sda_oe) |-> ack_hold_s) else $error("ack pulse too short");
  AST_OD:
    assert property (sda_o == 1'h0) else $error("sda driven high");
  AST_EDGE:
    assert property ($changed(sda_oe) |-> !scl) else $error("ack moved with scl high");
  AST_MAX:
    assert property (busy |-> cnt_q <= PROG_CYCLES) else $error("program cycle too long");
  AST_MIN:
    assert property ($fell(busy) |-> cnt_q == PROG_CYCLES) else $error("program length off");
  AST_QUIET:
    assert property (busy |-> !sda_oe) else $error("ack while programming");
  AST_SBY:
    assert property (busy |-> !standby) else $error("standby while programming");
  AST_WPB:
    assert property ($rose(busy) |-> !wp) else $error("program with wp high");
  AST_DIDLE:
    assert property (wr_dropped |-> idle_s) else $error("blocked write programmed");
  AST_PULSE:
    assert property (wr_dropped |=> !wr_dropped) else $error("drop flag not a pulse");
  AST_DWP:
    assert property (wr_dropped |-> wp) else $error("drop without wp");
endmodule // sesp_slave_port_sva
bind sesp_slave_port sesp_slave_port_sva #(.PROG_CYCLES(PROG_CYCLES)) sesp_slave_port_sva_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .scl(scl), .sda_o(sda_o), .sda_oe(sda_oe),
  .wp(wp), .standby(standby), .busy(busy), .wr_dropped(wr_dropped));

//--- tb/sesp_ctrl_model.sv
`timescale 1ns/1ns
module sesp_ctrl_model (
  input  wire logic link_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  // 128 ns phases so the input filter sees every edge
  task automatic half();
    repeat (4) @(posedge link_clk);
  endtask
  task automatic start();
    sda_low <= 1'h0;
    half();
    scl <= 1'h1;
    half();
    sda_low <= 1'h1;
    half();
    scl <= 1'h0;
    half();
  endtask
  task automatic stop();
    sda_low <= 1'h1;
    half();
    scl <= 1'h1;
    half();
    sda_low <= 1'h0;
    half();
  endtask
  task automatic bit_io(logic b, output logic r);
    sda_low <= ~b;
    half();
    scl <= 1'h1;
    half();
    r = sda;
    scl <= 1'h0;
    half();
  endtask
  task automatic put_byte(logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'h1, r);
    ack = ~r;
  endtask
endmodule // sesp_ctrl_model

//--- tb/test_serial_eeprom_slave_port.sv
`timescale 1ns/1ns
module test_serial_eeprom_slave_port;
  localparam int unsigned PC = 2000;
  logic        sys_clk, sys_rst, link_clk, wp, sda_o, sda_oe, standby, busy;
  logic        wr_dropped, ctl_low, scl, ack, r, seen_drop;
  logic [2:0]  cs;
  logic [15:0] word_addr, dbg_addr, a;
  logic [7:0]  dbg_data;
  logic [7:0]  ref_mem [logic [15:0]];
  logic [7:0]  q [$];
  logic [31:0] rng;
  int          n_mismatch, tests_run;
  wire logic   sda = ~(sda_oe | ctl_low);
  sesp_slave_port #(.PROG_CYCLES(PC)) sesp_slave_port_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .wp(wp), .chip_select_straps(cs),
    .standby(standby), .busy(busy), .wr_dropped(wr_dropped), .word_addr(word_addr),
    .dbg_addr(dbg_addr), .dbg_data(dbg_data));
  sesp_ctrl_model sesp_ctrl_model_i (.link_clk(link_clk), .sda(sda), .scl(scl),
    .sda_low(ctl_low));
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  // even-ns link edges never meet the odd-ns rising system edges
  initial begin
    link_clk = 1'h0;
    #4;
    forever #16 link_clk = ~link_clk;
  end
  always @(posedge sys_clk) if (wr_dropped === 1'h1) seen_drop <= 1'h1;
  initial begin
    #400000;
    n_mismatch++;
    close_out();
  end
  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(string n, logic e, logic g);
    chk8(n, {7'h0, e}, {7'h0, g});
  endtask
  task automatic send(logic [7:0] d, logic e);
    sesp_ctrl_model_i.put_byte(d, ack);
    chk1("ack", e, ack);
  endtask
  task automatic poll(logic e);
    sesp_ctrl_model_i.start();
    send({4'ha, cs, 1'h1}, e);
    sesp_ctrl_model_i.stop();
  endtask
  task automatic wr(logic [15:0] ad);
    logic [15:0] e;
    sesp_ctrl_model_i.start();
    send({4'ha, cs, 1'h0}, 1'h1);
    send(ad[15:8], 1'h1);
    send(ad[7:0], 1'h1);
    foreach (q[k]) begin
      send(q[k], 1'h1);
      if (!wp) ref_mem[{ad[15:7], 7'(ad[6:0] + k)}] = q[k];
    end
    sesp_ctrl_model_i.stop();
    e = {ad[15:7], 7'(ad[6:0] + q.size())};
    chk8("word_addr", e[15:8], word_addr[15:8]);
    chk8("word_addr", e[7:0], word_addr[7:0]);
  endtask
  task automatic prog();
    int i;
    chk1("busy", 1'h1, busy);
    chk1("standby", 1'h0, standby);
    poll(1'h0);
    i = 0;
    while (busy === 1'h1 && i < PC) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    chk1("busy", 1'h0, busy);
    poll(1'h1);
    chk1("standby", 1'h1, standby);
  endtask
  task automatic rd(logic [15:0] ad);
    @(posedge sys_clk);
    dbg_addr <= ad;
    repeat (2) @(posedge sys_clk);
    #1;
    chk8("mem", ref_mem[ad], dbg_data);
  endtask
  initial begin
    n_mismatch = 0;
    tests_run = 0;
    seen_drop = 1'h0;
    rng = xs(32'h1f);
    cs = rng[2:0];
    sys_rst = 1'h1;
    wp = 1'h0;
    dbg_addr = 16'h0;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'h0;
    repeat (10) @(posedge sys_clk);
    #1;
    chk1("standby", 1'h1, standby);
    for (int k = 0; k < 8; k++) begin
      sesp_ctrl_model_i.start();
      send({4'ha, 3'(k), 1'h1}, 1'(k == cs));
      sesp_ctrl_model_i.stop();
      chk1("standby", 1'h1, standby);
    end
    sesp_ctrl_model_i.start();
    send({4'hb, cs, 1'h0}, 1'h0);
    send({4'ha, cs, 1'h0}, 1'h0);
    sesp_ctrl_model_i.stop();
    sesp_ctrl_model_i.start();
    send({4'ha, cs, 1'h0}, 1'h1);
    repeat (3) sesp_ctrl_model_i.bit_io(1'h0, r);
    sesp_ctrl_model_i.start();
    repeat (9) sesp_ctrl_model_i.bit_io(1'h1, r);
    sesp_ctrl_model_i.start();
    sesp_ctrl_model_i.stop();
    rng = xs(rng);
    a = rng[15:0];
    q = {rng[23:16]};
    wr(a);
    prog();
    rd(a);
    q = {};
    for (int k = 0; k < 10; k++) begin
      rng = xs(rng);
      q.push_back(rng[7:0]);
    end
    a = {rng[31:23], 7'h7b};
    wr(a);
    prog();
    for (int k = 0; k < 10; k++) begin
      rd({a[15:7], 7'(a[6:0] + k)});
    end
    @(posedge sys_clk);
    wp <= 1'h1;
    repeat (8) @(posedge sys_clk);
    q = {~ref_mem[a]};
    wr(a);
    repeat (4) @(posedge sys_clk);
    chk1("dropped", 1'h1, seen_drop);
    chk1("busy", 1'h0, busy);
    wp <= 1'h0;
    rd(a);
    close_out();
  end
endmodule // test_serial_eeprom_slave_port
